//--- inc/pwm16_pkg.sv
// Package: register map, field positions and reset values of the 16-channel PWM
package pwm16_pkg;
   // Channel count and widths
   localparam int CHANNELS = 16;
   localparam int DUTY_W = 8;
   // Register byte offsets, one aligned word each
   localparam logic [7:0] OFS_DUTY0 = 8'h00;
   localparam logic [7:0] OFS_OE_LOW = 8'h40;
   localparam logic [7:0] OFS_OE_HIGH = 8'h44;
   localparam logic [7:0] OFS_POL_LOW = 8'h48;
   localparam logic [7:0] OFS_POL_HIGH = 8'h4C;
   localparam logic [7:0] OFS_PERIPHERAL_CLOCK_SELECT = 8'h50;
   localparam logic [7:0] OFS_CLK_EN = 8'h54;
   localparam logic [7:0] OFS_DIR_A = 8'h58;
   localparam logic [7:0] OFS_DIR_B = 8'h5C;
   localparam logic [7:0] OFS_PORT_DATA = 8'h60;
   localparam logic [7:0] OFS_SYS_CTRL = 8'h64;
   localparam logic [7:0] OFS_MSTOP = 8'h68;
   localparam logic [7:0] OFS_COUNTER = 8'h6C;
   localparam logic [7:0] OFS_PIN_LEVEL = 8'h70;
   // Field positions
   localparam int PERIPHERAL_CLOCK_SELECT_SEL_LSB = 1;
   localparam int CLK_EN_CKE_BIT = 0;
   localparam int CLK_EN_PSS_BIT = 1;
   localparam int SYS_IO_STROBE_ENABLE_BIT = 0;
   localparam int SYS_CHIP_SELECT_256_ENABLE_BIT = 1;
   localparam int MSTOP_BIT = 0;
   // Reset values
   localparam logic [7:0] DUTY_RESET = 8'h00;
   localparam logic [15:0] BITS16_RESET = 16'h0000;
   localparam logic [1:0] SEL_RESET = 2'h0;
   localparam logic MSTOP_RESET = 1'b1;
endpackage : pwm16_pkg

//--- hdl/pwm_lane.sv
// One channel's waveform: basic pulse plus spread additional pulses
`timescale 1ns/100ps
module pwm_lane (
   input wire logic [7:0] count,
   input wire logic [7:0] duty,
   input wire logic polarity,
   output logic wave
);
   logic [4:0] sum; // Position plus basic duty
   logic [3:0] slot; // Rank of this basic pulse in the spread order
   logic add_here; // This basic pulse gets an extra step
   logic high; // Waveform before polarity

   // Basic pulse ends at the period end, so its rising edge is at 16 - duty
   always_comb begin
      sum = {1'b0, count[3:0]} + {1'b0, duty[7:4]};
      // Bit-reversed rank of ~n; pulse 0 ranks 15 and is never picked
      slot = {~count[4], ~count[5], ~count[6], ~count[7]};
      add_here = slot < duty[3:0];
      // Extra step sits one step before the rising edge, even at duty 0
      high = sum[4] | (add_here & (sum == 5'h0F));
      wave = high ^ polarity;
   end
endmodule : pwm_lane

//--- hdl/pwm16_top.sv
// Sixteen-channel 8-bit PWM with APB registers and pin-state selection
// Summary of operation
// - Direction and enable choose input, port, PWM.
// - Enable bits map one-to-one onto channels.
// - Port output drives the port data bit.
// - Port output only in allowed modes, else address.
// - Select bits plus enables choose counter clock.
// - Off, system clock, or divide 2/4/8/16.
// - Select register bits 3, 0 read zero.
// - Upper nibble sets basic duty in sixteenths.
// - Sixteen basic pulses; lower nibble picks extras.
// - Extra step just before basic rising edge.
// - Extras keep timing when upper nibble zero.
// - Extras 15, 7, 11, 3, 13, 5 first.
// - Then odd pulses, then 14, 6, 10, 2.
// - Polarity bit selects direct or inverted output.
// - All duty registers reset to zero.
// - Starts in module stop; registers locked until cleared.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module pwm16_top
   import pwm16_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic single_chip_mode,
   input wire logic rom_ext_mode,
   input wire logic [15:0] address_bits,
   input wire logic [15:0] port_pin_level,
   output logic [15:0] channel_output_pin,
   output logic [15:0] channel_output_oe
);

   // Every flip-flop of the block lives in this one record
   typedef struct packed {
      logic [15:0][7:0] channel_duty_value; // Duty per channel
      logic [15:0] channel_output_enable; // Low and high enable bytes
      logic [15:0] channel_polarity; // 1 = inverted
      logic [1:0] clock_select; // {clock_select_high, clock_select_low}
      logic counter_clock_enable; // Counter clock on
      logic prescale_select; // 1 = divided clock
      logic [15:0] port_direction; // {port_b_direction, port_a_direction}
      logic [15:0] port_data_value; // Level for port output
      logic io_strobe_enable; // System control bits
      logic chip_select_256_enable;
      logic module_stop; // Halts the block
      logic [3:0] prescaler; // Free divider
      logic [7:0] pulse_counter; // Step and basic pulse number
      logic [1:0] mode_meta; // First synchroniser stage, modes
      logic [1:0] mode_sync; // {rom_ext, single_chip}
      logic [15:0] pin_meta; // First synchroniser stage, pins
      logic [15:0] pin_sync; // Synchronised pin levels
      logic [15:0] pin_out; // Output pin levels
      logic [15:0] pin_oe; // Output enables
      logic pready; // APB answer
      logic pslverr; // APB error
      logic [31:0] prdata; // APB read data
   } state_t;

   state_t st; // Registered state
   state_t next_st; // Next state
   logic [15:0] wave; // Lane waveforms
   logic tick; // Counter advance this cycle
   logic port_ok; // Pins may act as port outputs
   logic access_ok; // Current APB address usable
   logic do_write; // Write commits at this edge
   logic [31:0] rdata; // Read mux
   logic [3:0] div_mask; // Prescaler bits that must be all ones

   // One waveform generator per channel
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_lane
         pwm_lane u_lane (
            .count(st.pulse_counter),
            .duty(st.channel_duty_value[g]),
            .polarity(st.channel_polarity[g]),
            .wave(wave[g])
         );
      end
   endgenerate

   // Direct drive of outputs from the state record
   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign channel_output_pin = st.pin_out;
   assign channel_output_oe = st.pin_oe;

   // Next-state logic for registers, counter and pins
   always_comb begin
      next_st = st;
      // Two-stage synchronisers; stage one feeds only stage two
      next_st.mode_meta = {rom_ext_mode, single_chip_mode};
      next_st.mode_sync = st.mode_meta;
      next_st.pin_meta = port_pin_level;
      next_st.pin_sync = st.pin_meta;

      // Address decode; module stop locks all but its own register
      access_ok = 1'b0;
      rdata = 32'h0000_0000;
      if (paddr[7:6] == 2'b00 && paddr[1:0] == 2'b00) begin
         access_ok = 1'b1;
         rdata[7:0] = st.channel_duty_value[paddr[5:2]];
      end else begin
         access_ok = 1'b1;
         unique case (paddr)
            OFS_OE_LOW: rdata[7:0] = st.channel_output_enable[7:0];
            OFS_OE_HIGH: rdata[7:0] = st.channel_output_enable[15:8];
            OFS_POL_LOW: rdata[7:0] = st.channel_polarity[7:0];
            OFS_POL_HIGH: rdata[7:0] = st.channel_polarity[15:8];
            OFS_PERIPHERAL_CLOCK_SELECT: begin
               // Reserved bits 3 and 0 stay zero
               rdata[PERIPHERAL_CLOCK_SELECT_SEL_LSB+:2] = st.clock_select;
            end
            OFS_CLK_EN: begin
               rdata[CLK_EN_CKE_BIT] = st.counter_clock_enable;
               rdata[CLK_EN_PSS_BIT] = st.prescale_select;
            end
            OFS_DIR_A: rdata[7:0] = st.port_direction[7:0];
            OFS_DIR_B: rdata[7:0] = st.port_direction[15:8];
            OFS_PORT_DATA: begin
               rdata[15:0] = st.port_data_value;
            end
            OFS_SYS_CTRL: begin
               rdata[SYS_IO_STROBE_ENABLE_BIT] = st.io_strobe_enable;
               rdata[SYS_CHIP_SELECT_256_ENABLE_BIT] = st.chip_select_256_enable;
            end
            OFS_MSTOP: begin
               rdata[MSTOP_BIT] = st.module_stop;
            end
            OFS_COUNTER: begin
               rdata[7:0] = st.pulse_counter;
            end
            OFS_PIN_LEVEL: begin
               rdata[15:0] = st.pin_sync;
            end
            default: begin
               // Unmapped word answers with an error
               access_ok = 1'b0;
            end
         endcase
      end
      if (st.module_stop && paddr != OFS_MSTOP) begin
         access_ok = 1'b0;
      end
      if (!access_ok) begin
         rdata = 32'h0000_0000;
      end

      // APB: one wait state, then answer; write commits at the answer edge
      next_st.pready = psel & penable & ~st.pready;
      if (psel && penable && !st.pready) begin
         next_st.prdata = rdata;
         next_st.pslverr = ~access_ok;
      end else begin
         next_st.pslverr = 1'b0;
      end
      do_write = psel & penable & pwrite & st.pready & ~st.pslverr;

      // Register writes
      if (do_write) begin
         if (paddr[7:6] == 2'b00) begin
            next_st.channel_duty_value[paddr[5:2]] = pwdata[7:0];
         end else begin
            unique case (paddr)
               OFS_OE_LOW: begin
                  // Bit n of the low byte is channel n
                  next_st.channel_output_enable[7:0] = pwdata[7:0];
               end
               OFS_OE_HIGH: begin
                  // Bit n of the high byte is channel n + 8
                  next_st.channel_output_enable[15:8] = pwdata[7:0];
               end
               OFS_POL_LOW: begin
                  next_st.channel_polarity[7:0] = pwdata[7:0];
               end
               OFS_POL_HIGH: begin
                  next_st.channel_polarity[15:8] = pwdata[7:0];
               end
               OFS_PERIPHERAL_CLOCK_SELECT: begin
                  // Reserved bits are not stored at all
                  next_st.clock_select = pwdata[PERIPHERAL_CLOCK_SELECT_SEL_LSB+:2];
               end
               OFS_CLK_EN: begin
                  next_st.counter_clock_enable = pwdata[CLK_EN_CKE_BIT];
                  next_st.prescale_select = pwdata[CLK_EN_PSS_BIT];
               end
               OFS_DIR_A: begin
                  next_st.port_direction[7:0] = pwdata[7:0];
               end
               OFS_DIR_B: begin
                  next_st.port_direction[15:8] = pwdata[7:0];
               end
               OFS_PORT_DATA: begin
                  next_st.port_data_value = pwdata[15:0];
               end
               OFS_SYS_CTRL: begin
                  next_st.io_strobe_enable = pwdata[SYS_IO_STROBE_ENABLE_BIT];
                  next_st.chip_select_256_enable = pwdata[SYS_CHIP_SELECT_256_ENABLE_BIT];
               end
               OFS_MSTOP: begin
                  next_st.module_stop = pwdata[MSTOP_BIT];
               end
               default: begin
                  // Read-only words ignore writes
               end
            endcase
         end
      end

      // Clock choice: divisor 2, 4, 8, 16 from the select pair
      unique case (st.clock_select)
         2'b00: div_mask = 4'h1;
         2'b01: div_mask = 4'h3;
         2'b10: div_mask = 4'h7;
         2'b11: div_mask = 4'hF;
      endcase
      tick = 1'b0;
      if (st.counter_clock_enable && !st.module_stop) begin
         if (!st.prescale_select) begin
            tick = 1'b1;
         end else begin
            tick = (st.prescaler & div_mask) == div_mask;
         end
      end
      // Divider halts in module stop to save power
      if (!st.module_stop) begin
         next_st.prescaler = st.prescaler + 4'h1;
      end
      if (tick) begin
         next_st.pulse_counter = st.pulse_counter + 8'h01;
      end

      // Port output needs single-chip, or ROM mode with strobe on, 256 off
      port_ok = st.mode_sync[0] |
         (st.mode_sync[1] & st.io_strobe_enable & ~st.chip_select_256_enable);
      for (int i = 0; i < CHANNELS; i++) begin
         if (!st.port_direction[i]) begin
            // Input: pin released whatever the enable
            next_st.pin_oe[i] = 1'b0;
            next_st.pin_out[i] = 1'b0;
         end else if (!st.channel_output_enable[i]) begin
            next_st.pin_oe[i] = 1'b1;
            // Software must have set data to the full level for its polarity
            next_st.pin_out[i] = port_ok ? st.port_data_value[i]
               : address_bits[i];
         end else begin
            next_st.pin_oe[i] = 1'b1;
            next_st.pin_out[i] = wave[i];
         end
      end
   end

   // State register; reset gives zero duty, clock off, module stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.channel_duty_value <= {CHANNELS{DUTY_RESET}};
         st.channel_output_enable <= BITS16_RESET;
         st.clock_select <= SEL_RESET;
         st.module_stop <= MSTOP_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Checks on pins, counter, register bus and waveform
   property p_input_released;
      @(posedge pclk) disable iff (!presetn)
      !st.port_direction[0] |=> !channel_output_oe[0];
   endproperty
   a_input_released: assert property (p_input_released)
      else $error("pin driven while direction is input");

   property p_high_enable_map;
      @(posedge pclk) disable iff (!presetn)
      st.port_direction[9] && st.channel_output_enable[9]
         |=> channel_output_oe[9] && channel_output_pin[9] == $past(wave[9]);
   endproperty
   a_high_enable_map: assert property (p_high_enable_map)
      else $error("channel 9 not showing its waveform");

   property p_port_data;
      @(posedge pclk) disable iff (!presetn)
      st.port_direction[8] && !st.channel_output_enable[8] && port_ok
         |=> channel_output_pin[8] == $past(st.port_data_value[8]);
   endproperty
   a_port_data: assert property (p_port_data)
      else $error("port output does not follow data bit");

   property p_address_out;
      @(posedge pclk) disable iff (!presetn)
      st.port_direction[8] && !st.channel_output_enable[8] && !port_ok
         |=> channel_output_pin[8] == $past(address_bits[8]);
   endproperty
   a_address_out: assert property (p_address_out)
      else $error("address bit not on pin outside port mode");

   property p_clock_off;
      @(posedge pclk) disable iff (!presetn)
      !st.counter_clock_enable |=> st.pulse_counter == $past(st.pulse_counter);
   endproperty
   a_clock_off: assert property (p_clock_off)
      else $error("counter moved with clock disabled");

   property p_div16;
      @(posedge pclk) disable iff (!presetn)
      st.counter_clock_enable && st.prescale_select && st.clock_select == 2'b11
         && !st.module_stop && st.prescaler != 4'hF |=> $stable(st.pulse_counter);
   endproperty
   a_div16: assert property (p_div16)
      else $error("counter moved between divide-by-16 ticks");

   property p_system_clock;
      @(posedge pclk) disable iff (!presetn)
      st.counter_clock_enable && !st.prescale_select && !st.module_stop
         |=> st.pulse_counter == $past(st.pulse_counter) + 8'h01;
   endproperty
   a_system_clock: assert property (p_system_clock)
      else $error("counter not advancing on system clock");

   property p_reserved_zero;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && pready && !pwrite && paddr == OFS_PERIPHERAL_CLOCK_SELECT
         |-> prdata[3] == 1'b0 && prdata[0] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved select bits read nonzero");

   property p_basic_tail;
      @(posedge pclk) disable iff (!presetn)
      st.pulse_counter[3:0] == 4'hF && st.channel_duty_value[2][7:4] != 4'h0
         && !st.channel_polarity[2] |-> wave[2];
   endproperty
   a_basic_tail: assert property (p_basic_tail)
      else $error("basic pulse low in its last step");

   property p_last_extra;
      @(posedge pclk) disable iff (!presetn)
      st.pulse_counter[7:4] == 4'hF && st.channel_duty_value[2][3:0] != 4'h0
         && st.pulse_counter[3:0] + st.channel_duty_value[2][7:4] == 4'hF
         && !st.channel_polarity[2] |-> wave[2];
   endproperty
   a_last_extra: assert property (p_last_extra)
      else $error("missing additional pulse in basic pulse 15");

   property p_stop_locks;
      @(posedge pclk) disable iff (!presetn)
      st.module_stop |=> $stable(st.pulse_counter) && $stable(st.channel_duty_value);
   endproperty
   a_stop_locks: assert property (p_stop_locks)
      else $error("block changed while in module stop");

endmodule : pwm16_top

//--- verif/pin_loads.sv
// Model of the loads on the sixteen channel pins: filters with a pull-down path
`timescale 1ns/100ps
module pin_loads (
   input wire logic [15:0] channel_output_pin,
   input wire logic [15:0] channel_output_oe,
   output logic [15:0] port_pin_level
);
   // An undriven pin is pulled low by the filter resistor, never left at its last value
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         port_pin_level[i] = channel_output_oe[i] ? channel_output_pin[i] : 1'b0;
      end
   end
endmodule : pin_loads

//--- verif/tb.sv
// Self-checking testbench of the sixteen-channel PWM
`timescale 1ns/100ps
module tb;
   import pwm16_pkg::*;
   // Register row and waveform row types
   typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} reg_row_t;
   typedef struct packed {logic [7:0] duty; logic pol; logic [8:0] high_count;} wave_row_t;
   // Order in which basic pulses receive an additional pulse
   localparam logic [3:0] EXTRA_ORDER [0:14] = '{4'hF, 4'h7, 4'hB, 4'h3, 4'hD, 4'h5, 4'h9,
      4'h1, 4'hE, 4'h6, 4'hA, 4'h2, 4'hC, 4'h4, 4'h8};
   localparam reg_row_t REG_ROWS [0:7] = '{'{8'h40, 32'hFF, 32'hFF, 1'b0},
      '{8'h44, 32'hA5, 32'hA5, 1'b0}, '{8'h50, 32'hF, 32'h6, 1'b0}, '{8'h7C, 32'h1, 32'h0, 1'b1},
      '{8'h02, 32'h1, 32'h0, 1'b1}, '{8'h40, 32'h0, 32'h0, 1'b0}, '{8'h44, 32'h0, 32'h0, 1'b0},
      '{8'h50, 32'h0, 32'h0, 1'b0}};
   // Even rows direct, odd rows inverted; every lower-nibble code appears once
   localparam wave_row_t WAVE_ROWS [0:15] = '{'{8'h00, 1'b0, 9'h000}, '{8'h01, 1'b1, 9'h0FF},
      '{8'h12, 1'b0, 9'h012}, '{8'h23, 1'b1, 9'h0DD}, '{8'h34, 1'b0, 9'h034},
      '{8'h45, 1'b1, 9'h0BB}, '{8'h56, 1'b0, 9'h056}, '{8'h67, 1'b1, 9'h099},
      '{8'h78, 1'b0, 9'h078}, '{8'h89, 1'b1, 9'h077}, '{8'h9A, 1'b0, 9'h09A},
      '{8'hAB, 1'b1, 9'h055}, '{8'hBC, 1'b0, 9'h0BC}, '{8'hCD, 1'b1, 9'h033},
      '{8'hEE, 1'b0, 9'h0EE}, '{8'hFF, 1'b1, 9'h001}};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic single_chip_mode, rom_ext_mode;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, rd2;
   logic [15:0] address_bits, port_pin_level, channel_output_pin, channel_output_oe;
   logic [255:0] got, expv;
   int errors, tests_run, w, p;
   // One comparison: counted, and reported at once on a mismatch
   `define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end

   pwm16_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .single_chip_mode(single_chip_mode), .rom_ext_mode(rom_ext_mode),
      .address_bits(address_bits), .port_pin_level(port_pin_level),
      .channel_output_pin(channel_output_pin), .channel_output_oe(channel_output_oe));
   pin_loads u_loads (.channel_output_pin(channel_output_pin),
      .channel_output_oe(channel_output_oe), .port_pin_level(port_pin_level));

   // Clock of 50 ns
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Verdict and end of run
   task automatic complete_run;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : complete_run

   // One APB transfer; waits for pready with no assumed latency, only the watchdog ends it
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Expected level of a lane for counter value c
   function automatic logic expect_level(logic [7:0] c, logic [7:0] duty, logic pol);
      int s;
      int u;
      logic extra;
      s = c[3:0];
      u = duty[7:4];
      extra = 1'b0;
      for (int k = 0; k < 15; k++) if (k < duty[3:0] && EXTRA_ORDER[k] == c[7:4]) extra = 1'b1;
      return ((s + u >= 16) || (extra && s + u == 15)) ^ pol;
   endfunction : expect_level

   // Reference lane 3 (duty 01) is high only at counter FF, so it marks the period start
   task automatic capture;
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (channel_output_pin[3] !== 1'b1 && n < 20000);
      for (int t = 0; t < 256; t++) begin
         @(negedge pclk);
         got[t] = channel_output_pin[2];
      end
   endtask : capture

   // High width and period of the reference lane, in pclk cycles
   task automatic measure(output int hw, output int per);
      int n;
      n = 0;
      while (channel_output_pin[3] !== 1'b0 && n < 20000) begin @(negedge pclk); n++; end
      while (channel_output_pin[3] !== 1'b1 && n < 20000) begin @(negedge pclk); n++; end
      hw = 0;
      while (channel_output_pin[3] === 1'b1 && hw < 100) begin @(negedge pclk); hw++; end
      per = hw;
      while (channel_output_pin[3] !== 1'b1 && per < 20000) begin @(negedge pclk); per++; end
   endtask : measure

   // Watchdog: about one and a half times the expected run length
   initial begin
      #(60000 * 50);
      errors++;
      complete_run();
   end

   // Main sequence
   initial begin
      errors = 0;
      tests_run = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      single_chip_mode = 1'b1;
      rom_ext_mode = 1'b0;
      address_bits = 16'h0000;
      repeat (20) @(posedge pclk);
      `CHECK({pready, pslverr, channel_output_oe}, 18'h00000)
      presetn <= 1'b1;
      // Module stop holds everything but its own control register
      apb(1'b0, 8'h68, 32'h0, rd, er);
      `CHECK({er, rd}, 33'h000000001)
      apb(1'b1, 8'h40, 32'hFF, rd, er);
      `CHECK(er, 1'b1)
      apb(1'b1, 8'h68, 32'h0, rd, er);
      // Reset values of duty 0-3, polarity high, clock select, clock enable and port A direction registers
      foreach (REG_ROWS[i]) begin
         apb(1'b0, (i < 4) ? 8'(i * 4) : 8'(8'h3C + i * 4), 32'h0, rd, er);
         `CHECK({er, rd}, 33'h0)
      end
      foreach (REG_ROWS[i]) begin
         apb(1'b1, REG_ROWS[i].a, REG_ROWS[i].w, rd, er);
         apb(1'b0, REG_ROWS[i].a, 32'h0, rd, er);
         `CHECK({er, rd}, {REG_ROWS[i].e, REG_ROWS[i].r})
      end
      // Channel 8 port output, channel 9 PWM at duty 0, others inputs
      apb(1'b1, 8'h60, 32'h0100, rd, er);
      apb(1'b1, 8'h5C, 32'h03, rd, er);
      apb(1'b1, 8'h44, 32'h02, rd, er);
      repeat (5) @(posedge pclk);
      `CHECK({channel_output_oe, channel_output_pin}, 32'h03000100)
      apb(1'b0, 8'h70, 32'h0, rd, er);
      `CHECK(rd[15:0], 16'h0100)
      apb(1'b1, 8'h4C, 32'h02, rd, er);
      repeat (3) @(posedge pclk);
      `CHECK(channel_output_pin[9:8], 2'b11)
      // Extended mode: port output only with strobe enabled and chip select 256 off
      single_chip_mode <= 1'b0;
      rom_ext_mode <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         // Address lines low for m of 0 and high for 2 and 3, so both levels pass through
         address_bits <= {16{m[1]}};
         apb(1'b1, 8'h64, 32'(m), rd, er);
         repeat (5) @(posedge pclk);
         `CHECK(channel_output_pin[8], (m == 1) | m[1])
      end
      single_chip_mode <= 1'b1;
      // Lanes 2 and 3 in PWM at the system clock; lane 3 is the period marker
      apb(1'b1, 8'h58, 32'h0C, rd, er);
      apb(1'b1, 8'h40, 32'h0C, rd, er);
      apb(1'b1, 8'h0C, 32'h01, rd, er);
      apb(1'b1, 8'h54, 32'h1, rd, er);
      foreach (WAVE_ROWS[i]) begin
         apb(1'b1, 8'h08, 32'(WAVE_ROWS[i].duty), rd, er);
         apb(1'b1, 8'h48, 32'(WAVE_ROWS[i].pol) << 2, rd, er);
         for (int t = 0; t < 256; t++) expv[t] = expect_level(8'(t), WAVE_ROWS[i].duty,
            WAVE_ROWS[i].pol);
         capture();
         `CHECK(got, expv)
         `CHECK(9'($countones(WAVE_ROWS[i].pol ? ~got : got)), 9'(WAVE_ROWS[i].duty))
         `CHECK(9'($countones(got)), WAVE_ROWS[i].high_count)
      end
      // Prescaler: one resolution step lasts 2, 4, 8, 16 cycles
      measure(w, p);
      `CHECK(p, 256)
      apb(1'b1, 8'h54, 32'h3, rd, er);
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, 8'h50, 32'(s) << 1, rd, er);
         measure(w, p);
         measure(w, p);
         `CHECK({w, p}, {32'(2 << s), 32'(512 << s)})
      end
      // Clock input disabled: the counter holds still
      apb(1'b1, 8'h54, 32'h0, rd, er);
      apb(1'b0, 8'h6C, 32'h0, rd, er);
      repeat (40) @(posedge pclk);
      // The counter word is read-only: a write is ignored without an error
      apb(1'b1, 8'h6C, 32'h55, rd2, er);
      `CHECK(er, 1'b0)
      apb(1'b0, 8'h6C, 32'h0, rd2, er);
      `CHECK(rd2, rd)
      // Reset in mid-run: pins released, module stop back, duty cleared
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHECK({pready, pslverr, channel_output_oe, channel_output_pin}, 34'h0)
      presetn <= 1'b1;
      apb(1'b0, 8'h68, 32'h0, rd, er);
      `CHECK({er, rd}, 33'h000000001)
      apb(1'b0, 8'h08, 32'h0, rd, er);
      `CHECK(er, 1'b1)
      apb(1'b1, 8'h68, 32'h0, rd, er);
      apb(1'b0, 8'h08, 32'h0, rd, er);
      `CHECK({er, rd}, 33'h0)
      complete_run();
   end
endmodule : tb
